// ==== logic/eeprom_pkg.sv ====
// Shared constants of the two-wire EEPROM device and its host controller.
// Assumes a 50 MHz system clock on both ends.
package eeprom_pkg;

  // ---------------------------------------------------------------
  // Memory geometry and address fields
  // ---------------------------------------------------------------
  localparam int unsigned ADDR_W           = 16;
  localparam int unsigned ARRAY_BYTES      = 65536;
  localparam int unsigned ID_PAGE_BYTES    = 128;
  localparam int unsigned PAGE_OFFSET_W    = 7;
  localparam int unsigned ID_READ_OFFSET_W = 6;
  localparam int unsigned LOCK_SELECT_ADDRESS_BIT = 10;
  localparam int unsigned LOCK_DATA_BIT    = 1;

  // ---------------------------------------------------------------
  // Device address byte and bit framing
  // ---------------------------------------------------------------
  localparam logic [3:0] ARRAY_TYPE_ID = 4'h a;
  localparam logic [3:0] ID_TYPE_ID    = 4'h b;
  localparam logic [3:0] BYTE_BITS     = 4'h8;
  localparam logic [3:0] ACK_BIT       = 4'h9;

  // ---------------------------------------------------------------
  // Timing
  // ---------------------------------------------------------------
  localparam int unsigned CLK_FREQ_MHZ   = 50;
  localparam int unsigned CLK_PERIOD_NS  = 20;
  localparam int unsigned INTERNAL_WRITE_TIME_US = 3000;
  localparam int unsigned WRITE_TIME_CYCLES =
    INTERNAL_WRITE_TIME_US * CLK_FREQ_MHZ;
  localparam int unsigned SCL_QUARTER_NS = 260;
  localparam int unsigned SCL_QUARTER_CYCLES =
    (SCL_QUARTER_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  // ---------------------------------------------------------------
  // Host register map and command codes
  // ---------------------------------------------------------------
  localparam logic [7:0] CMD_OFFSET    = 8'h00;
  localparam logic [7:0] TXDATA_OFFSET = 8'h04;
  localparam logic [7:0] RXDATA_OFFSET = 8'h08;
  localparam logic [7:0] STATUS_OFFSET = 8'h0c;
  localparam logic [2:0] OP_START = 3'h1;
  localparam logic [2:0] OP_STOP  = 3'h2;
  localparam logic [2:0] OP_WRITE = 3'h3;
  localparam logic [2:0] OP_READ  = 3'h4;
  localparam int unsigned CMD_ACK_BIT      = 3;
  localparam int unsigned STATUS_BUSY_BIT  = 0;
  localparam int unsigned STATUS_ACKED_BIT = 1;
  localparam logic [1:0] HTRANS_NONSEQ = 2'h2;

endpackage : eeprom_pkg

// ==== logic/two_wire_if.sv ====
// Open-drain two-wire bus joining the host controller and the EEPROM.
// Each party gives an output value and an enable; the wire levels are
// resolved here as a pulled-up wired AND.
`timescale 1ns/1ns
`default_nettype none

interface two_wire_if;
  logic host_scl_o;
  logic host_scl_oe;
  logic host_sda_o;
  logic host_sda_oe;
  logic dev_sda_o;
  logic dev_sda_oe;
  logic scl;
  logic sda;

  // A driver pulls low only while enabled; otherwise the pull-up wins.
  assign scl = !(host_scl_oe && !host_scl_o);
  assign sda = !(host_sda_oe && !host_sda_o) && !(dev_sda_oe && !dev_sda_o);

  modport device (input scl, input sda, output dev_sda_o, output dev_sda_oe);
  modport host (input scl, input sda, output host_scl_o, output host_scl_oe,
                output host_sda_o, output host_sda_oe);
endinterface : two_wire_if

`default_nettype wire

// ==== logic/eeprom_device.sv ====
// Two-wire serial EEPROM: array, identification page and its lock.
// Assumes the host makes the serial clock well below clk / 8; both
// bus lines are resynchronised to clk before any logic reads them.
`timescale 1ns/1ns
`default_nettype none

module eeprom_device
  import eeprom_pkg::*;
#(
  parameter int unsigned MEM_BYTES    = ARRAY_BYTES,
  parameter int unsigned WRITE_CYCLES = WRITE_TIME_CYCLES
) (
  input  wire logic       clk,
  input  wire logic       rst_n,
  two_wire_if.device      bus,
  input  wire logic [2:0] chip_select_pins,
  input  wire logic       write_protect,
  output logic            id_locked,
  output logic            write_busy
);

  typedef enum logic [2:0] {
    ST_IDLE, ST_DEV_ADDR, ST_ADDR_HIGH, ST_ADDR_LOW, ST_WRITE_DATA,
    ST_READ_DATA, ST_HOLD, ST_WRITE_CYCLE
  } dev_state_type;

  // ---------------------------------------------------------------
  // Storage
  // ---------------------------------------------------------------
  logic [7:0]        mem [MEM_BYTES];
  logic [7:0]        id_mem [ID_PAGE_BYTES];
  // The lock is nonvolatile: no reset clears it, only configuration.
  logic              id_locked_reg = 1'b0;

  dev_state_type     state_reg;
  logic [3:0]        bit_cnt_reg;
  logic [7:0]        shift_reg;
  logic [ADDR_W-1:0] counter_reg;
  logic              sda_low_reg;
  logic              id_sel_reg;
  logic              wrote_reg;
  logic              host_ack_reg;
  logic [31:0]       busy_cnt_reg;
  logic              scl_meta, scl_sync, scl_prev;
  logic              sda_meta, sda_sync, sda_prev;
  logic              scl_rise, scl_fall, start_seen, stop_seen;
  logic              byte_done, in_write, array_we, id_we, lock_we;
  logic              addr_match;
  logic [7:0]        rd_byte;

  // Next address for a read: the whole array, top wraps to zero.
  function automatic logic [ADDR_W-1:0] read_next(logic [ADDR_W-1:0] a);
    read_next = a + 1'b1;
  endfunction : read_next

  // Next address for a write: only the in-page offset moves.
  function automatic logic [ADDR_W-1:0] page_next(logic [ADDR_W-1:0] a);
    page_next = {a[ADDR_W-1:PAGE_OFFSET_W],
                 a[PAGE_OFFSET_W-1:0] + 1'b1};
  endfunction : page_next

  // ---------------------------------------------------------------
  // Bus line synchronisers and condition detection
  // ---------------------------------------------------------------
  // Two flops per line; a third stage only feeds the edge detectors.
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      scl_meta <= 1'b1;
      scl_sync <= 1'b1;
      scl_prev <= 1'b1;
      sda_meta <= 1'b1;
      sda_sync <= 1'b1;
      sda_prev <= 1'b1;
    end else begin
      scl_meta <= bus.scl;
      scl_sync <= scl_meta;
      scl_prev <= scl_sync;
      sda_meta <= bus.sda;
      sda_sync <= sda_meta;
      sda_prev <= sda_sync;
    end
  end

  assign scl_rise   = scl_sync && !scl_prev;
  assign scl_fall   = !scl_sync && scl_prev;
  assign start_seen = scl_sync && scl_prev && sda_prev && !sda_sync;
  assign stop_seen  = scl_sync && scl_prev && !sda_prev && sda_sync;

  // ---------------------------------------------------------------
  // Byte decode and store strobes
  // ---------------------------------------------------------------
  // A byte is complete on the clock fall that ends its eighth bit.
  assign byte_done = scl_fall && bit_cnt_reg == BYTE_BITS &&
                     !start_seen && !stop_seen;
  assign in_write  = byte_done && state_reg == ST_WRITE_DATA;
  assign array_we  = in_write && !id_sel_reg && !write_protect;
  // Address bit ten chooses between page write and the lock order.
  assign id_we     = in_write && id_sel_reg && !id_locked_reg &&
                     !counter_reg[LOCK_SELECT_ADDRESS_BIT];
  assign lock_we   = in_write && id_sel_reg &&
                     counter_reg[LOCK_SELECT_ADDRESS_BIT] &&
                     shift_reg[LOCK_DATA_BIT];
  assign addr_match = (shift_reg[7:4] == ARRAY_TYPE_ID ||
                       shift_reg[7:4] == ID_TYPE_ID) &&
                      shift_reg[3:1] == chip_select_pins;

  // Identification reads ignore the high address bits.
  assign rd_byte = id_sel_reg ?
    id_mem[{1'b0, counter_reg[ID_READ_OFFSET_W-1:0]}] :
    mem[counter_reg];

  // Array and page writes are committed as each byte is accepted.
  always_ff @(posedge clk) begin
    if (array_we) begin
      mem[counter_reg] <= shift_reg;
    end
    if (id_we) begin
      id_mem[counter_reg[PAGE_OFFSET_W-1:0]] <= shift_reg;
    end
  end

  // Once set the lock has no path back to zero.
  always_ff @(posedge clk) begin
    if (lock_we) begin
      id_locked_reg <= 1'b1;
    end
  end

  // ---------------------------------------------------------------
  // Internal write timer
  // ---------------------------------------------------------------
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      busy_cnt_reg <= 32'h0000_0000;
    end else if (state_reg == ST_WRITE_CYCLE) begin
      busy_cnt_reg <= busy_cnt_reg + 32'h0000_0001;
    end else begin
      busy_cnt_reg <= 32'h0000_0000;
    end
  end

  // ---------------------------------------------------------------
  // Protocol engine
  // ---------------------------------------------------------------
  // Data is taken on clock rise and driven after clock fall; the
  // counter is only lost with reset, standing in for power loss.
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      state_reg    <= ST_IDLE;
      bit_cnt_reg  <= 4'h0;
      shift_reg    <= 8'h00;
      counter_reg  <= 16'h0000;
      sda_low_reg  <= 1'b0;
      id_sel_reg   <= 1'b0;
      wrote_reg    <= 1'b0;
      host_ack_reg <= 1'b0;
    end else if (state_reg == ST_WRITE_CYCLE) begin
      // Deaf until the write time has run out, so polls get no ack.
      sda_low_reg <= 1'b0;
      wrote_reg   <= 1'b0;
      if (busy_cnt_reg >= WRITE_CYCLES - 1) begin
        state_reg <= ST_IDLE;
      end
    end else if (start_seen) begin
      state_reg   <= ST_DEV_ADDR;
      bit_cnt_reg <= 4'h0;
      sda_low_reg <= 1'b0;
    end else if (stop_seen) begin
      sda_low_reg <= 1'b0;
      state_reg   <= wrote_reg ? ST_WRITE_CYCLE : ST_IDLE;
    end else if (state_reg == ST_READ_DATA && bit_cnt_reg <= BYTE_BITS) begin
      if (scl_rise && bit_cnt_reg == BYTE_BITS) begin
        host_ack_reg <= !sda_sync;
        bit_cnt_reg  <= ACK_BIT;
      end else if (scl_rise) begin
        bit_cnt_reg <= bit_cnt_reg + 4'h1;
      end else if (scl_fall && bit_cnt_reg == BYTE_BITS) begin
        sda_low_reg <= 1'b0;
      end else if (scl_fall && bit_cnt_reg != 4'h0) begin
        shift_reg   <= {shift_reg[6:0], 1'b1};
        sda_low_reg <= !shift_reg[6];
      end
    end else if (byte_done) begin
      bit_cnt_reg <= ACK_BIT;
      // Ack is driven from this fall until the fall of the ninth clock.
      unique case (state_reg)
        ST_DEV_ADDR: begin
          sda_low_reg  <= addr_match;
          id_sel_reg   <= shift_reg[7:4] == ID_TYPE_ID;
          host_ack_reg <= 1'b1;
          state_reg    <= !addr_match ? ST_IDLE :
                          shift_reg[0] ? ST_READ_DATA : ST_ADDR_HIGH;
        end
        ST_ADDR_HIGH: begin
          sda_low_reg <= 1'b1;
          counter_reg[ADDR_W-1:8] <= shift_reg;
          state_reg   <= ST_ADDR_LOW;
        end
        ST_ADDR_LOW: begin
          sda_low_reg <= 1'b1;
          counter_reg[7:0] <= shift_reg;
          state_reg   <= ST_WRITE_DATA;
        end
        ST_WRITE_DATA: begin
          if (id_sel_reg && id_locked_reg &&
              !counter_reg[LOCK_SELECT_ADDRESS_BIT]) begin
            state_reg <= ST_HOLD;
          end else begin
            sda_low_reg <= 1'b1;
            wrote_reg   <= 1'b1;
            counter_reg <= page_next(counter_reg);
          end
        end
        default: begin
          sda_low_reg <= 1'b0;
        end
      endcase
    end else if (scl_fall && bit_cnt_reg == ACK_BIT) begin
      // End of the ninth clock: release, then send a byte if reading and the host acked.
      bit_cnt_reg <= 4'h0;
      sda_low_reg <= 1'b0;
      if (state_reg == ST_READ_DATA && host_ack_reg) begin
        shift_reg   <= rd_byte;
        sda_low_reg <= !rd_byte[7];
        counter_reg <= read_next(counter_reg);
      end else if (state_reg == ST_READ_DATA) begin
        state_reg <= ST_HOLD;
      end
    end else if (scl_rise && bit_cnt_reg < BYTE_BITS &&
                 state_reg != ST_IDLE && state_reg != ST_HOLD) begin
      shift_reg   <= {shift_reg[6:0], sda_sync};
      bit_cnt_reg <= bit_cnt_reg + 4'h1;
    end
  end

  // ---------------------------------------------------------------
  // Outputs
  // ---------------------------------------------------------------
  assign bus.dev_sda_o  = 1'b0;
  assign bus.dev_sda_oe = sda_low_reg;
  assign id_locked      = id_locked_reg;
  assign write_busy     = state_reg == ST_WRITE_CYCLE;

endmodule : eeprom_device

`default_nettype wire

// ==== logic/eeprom_host.sv ====
// Two-wire bus host controller, ordered over AHB-Lite one bus step at a
// time: start, stop, write byte, read byte.
// Assumes a single AHB-Lite master and slave; software sequences the
// steps into reads, writes and lock orders.
`timescale 1ns/1ns
`default_nettype none

module eeprom_host
  import eeprom_pkg::*;
#(
  parameter int unsigned QUARTER_CYCLES = SCL_QUARTER_CYCLES
) (
  input  wire logic        clk,
  input  wire logic        rst_n,
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic             hreadyout,
  output logic [31:0]      hrdata,
  output logic             hresp,
  two_wire_if.host         bus
);

  typedef enum logic [1:0] {H_IDLE, H_START, H_STOP, H_BIT} host_state_type;

  host_state_type state_reg;
  logic [1:0]     phase_reg;
  logic [15:0]    quarter_cnt_reg;
  logic [3:0]     bit_idx_reg;
  logic           op_write_reg;
  logic           ack_send_reg;
  logic [7:0]     tx_reg;
  logic [7:0]     rx_reg;
  logic           acked_reg;
  logic           scl_high_reg;
  logic           sda_high_reg;
  logic           sda_meta, sda_sync;
  logic           wr_pend_reg;
  logic [7:0]     wr_addr_reg;
  logic [31:0]    hrdata_reg;
  logic           addr_phase, tick, launch, bit_level;

  // ---------------------------------------------------------------
  // AHB-Lite slave: zero wait states, always OKAY
  // ---------------------------------------------------------------
  assign addr_phase = hsel && hready && htrans == HTRANS_NONSEQ;
  assign hreadyout  = 1'b1;
  assign hresp      = 1'b0;
  assign hrdata     = hrdata_reg;
  // A command is taken only while no bus step is running.
  assign launch     = wr_pend_reg && wr_addr_reg == CMD_OFFSET &&
                      state_reg == H_IDLE;

  // Address phase is captured; read data is ready for the data phase.
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      wr_pend_reg <= 1'b0;
      wr_addr_reg <= 8'h00;
      hrdata_reg  <= 32'h0000_0000;
    end else begin
      wr_pend_reg <= addr_phase && hwrite;
      wr_addr_reg <= haddr[7:0];
      if (addr_phase && !hwrite) begin
        unique case (haddr[7:0])
          RXDATA_OFFSET: hrdata_reg <= {24'h00_0000, rx_reg};
          TXDATA_OFFSET: hrdata_reg <= {24'h00_0000, tx_reg};
          STATUS_OFFSET: hrdata_reg <= {30'h0000_0000, acked_reg,
                                        state_reg != H_IDLE};
          default:       hrdata_reg <= 32'h0000_0000;
        endcase
      end
    end
  end

  // ---------------------------------------------------------------
  // Line sampling and quarter-period timer
  // ---------------------------------------------------------------
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      sda_meta        <= 1'b1;
      sda_sync        <= 1'b1;
      quarter_cnt_reg <= 16'h0000;
    end else begin
      sda_meta <= bus.sda;
      sda_sync <= sda_meta;
      if (state_reg == H_IDLE || tick) begin
        quarter_cnt_reg <= 16'h0000;
      end else begin
        quarter_cnt_reg <= quarter_cnt_reg + 16'h0001;
      end
    end
  end

  assign tick = state_reg != H_IDLE &&
                quarter_cnt_reg == 16'(QUARTER_CYCLES - 1);
  // Write byte: data then release for the ack; read: release then ack or nack, as the command's ack bit asks.
  assign bit_level = (bit_idx_reg < BYTE_BITS) ?
                     (!op_write_reg || tx_reg[7]) :
                     (op_write_reg || !ack_send_reg);

  // ---------------------------------------------------------------
  // Bus step engine
  // ---------------------------------------------------------------
  // Each step begins with the clock low, so the data line only moves
  // while the clock is low, except for start and stop.
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      state_reg    <= H_IDLE;
      phase_reg    <= 2'h0;
      bit_idx_reg  <= 4'h0;
      op_write_reg <= 1'b0;
      ack_send_reg <= 1'b0;
      tx_reg       <= 8'h00;
      rx_reg       <= 8'h00;
      acked_reg    <= 1'b0;
      scl_high_reg <= 1'b1;
      sda_high_reg <= 1'b1;
    end else if (state_reg == H_IDLE) begin
      if (wr_pend_reg && wr_addr_reg == TXDATA_OFFSET) begin
        // Device address, word address and lock bytes come from here.
        tx_reg <= hwdata[7:0];
      end
      if (launch) begin
        phase_reg    <= 2'h0;
        bit_idx_reg  <= 4'h0;
        op_write_reg <= hwdata[2:0] == OP_WRITE;
        ack_send_reg <= hwdata[CMD_ACK_BIT];
        scl_high_reg <= 1'b0;
        unique case (hwdata[2:0])
          OP_START: state_reg <= H_START;
          OP_STOP:  state_reg <= H_STOP;
          OP_WRITE: state_reg <= H_BIT;
          OP_READ:  state_reg <= H_BIT;
          default:  scl_high_reg <= scl_high_reg;
        endcase
      end
    end else if (tick) begin
      phase_reg <= phase_reg + 2'h1;
      unique case (state_reg)
        H_START: begin
          sda_high_reg <= phase_reg != 2'h2 && (phase_reg == 2'h0 ||
                          sda_high_reg);
          scl_high_reg <= phase_reg != 2'h0;
          if (phase_reg == 2'h3) state_reg <= H_IDLE;
        end
        H_STOP: begin
          sda_high_reg <= phase_reg >= 2'h2;
          scl_high_reg <= phase_reg != 2'h0;
          if (phase_reg == 2'h3) state_reg <= H_IDLE;
        end
        default: begin
          if (phase_reg == 2'h0) sda_high_reg <= bit_level;
          if (phase_reg == 2'h1) scl_high_reg <= 1'b1;
          if (phase_reg == 2'h3) begin
            scl_high_reg <= 1'b0;
            bit_idx_reg  <= bit_idx_reg + 4'h1;
            if (bit_idx_reg < BYTE_BITS) begin
              rx_reg <= {rx_reg[6:0], sda_sync};
              tx_reg <= {tx_reg[6:0], 1'b1};
            end else begin
              acked_reg <= !sda_sync;
              state_reg <= H_IDLE;
            end
          end
        end
      endcase
    end
  end

  assign bus.host_scl_o  = 1'b0;
  assign bus.host_scl_oe = !scl_high_reg;
  assign bus.host_sda_o  = 1'b0;
  assign bus.host_sda_oe = !sda_high_reg;

endmodule : eeprom_host

`default_nettype wire

// ==== testbench/two_wire_properties.sv ====
// Checks on the two-wire link between the host and the EEPROM.
// Assumes it sits beside the interface and samples its wires on clk.
`timescale 1ns/1ns
`default_nettype none
module two_wire_properties #(
  parameter int unsigned QUARTER_CYCLES = 4
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic host_sda_oe,
  input wire logic dev_sda_oe,
  input wire logic scl,
  input wire logic sda
);
  localparam int HI = 2 * QUARTER_CYCLES;
  logic        scl_d;
  logic        sda_d;
  logic        first;
  logic [3:0]  pos;
  logic [15:0] hi_len;
  wire         start = scl & scl_d & sda_d & ~sda;
  wire         stop  = scl & scl_d & ~sda_d & sda;
  wire         rise  = scl & ~scl_d;
  // ------------------------------------------------------------
  // Bit position since the last start and length of scl high
  // ------------------------------------------------------------
  // Reset and stop both leave a frame due next, so the long idle high
  // time before the next start is not taken for a data bit.
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      {scl_d, sda_d, first, pos, hi_len} <= {3'h7, 4'h0, 16'h0};
    end else begin
      scl_d  <= scl;
      sda_d  <= sda;
      hi_len <= scl ? hi_len + 16'h1 : 16'h0;
      if (start || stop) begin
        pos   <= 4'h0;
        first <= 1'b1;
      end else if (rise) begin
        pos   <= (pos == 4'h8) ? 4'h0 : pos + 4'h1;
        first <= first && (pos != 4'h8);
      end
    end
  end
  // ------------------------------------------------------------
  // Properties
  // ------------------------------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);
  property p_ack_ninth; rise && first && dev_sda_oe |-> pos == 4'h8; endproperty
  a_ack_ninth: assert property (p_ack_ninth)
    else $error("device drove inside an address byte");
  property p_ack_hold; rise && dev_sda_oe |-> dev_sda_oe [*4]; endproperty
  a_ack_hold: assert property (p_ack_hold)
    else $error("device bit not held while scl high");
  property p_dev_low; $changed(dev_sda_oe) |-> !scl; endproperty
  a_dev_low: assert property (p_dev_low)
    else $error("device changed sda while scl high");
  property p_no_clash; rise |-> !(dev_sda_oe && host_sda_oe); endproperty
  a_no_clash: assert property (p_no_clash)
    else $error("both ends drive sda");
  property p_nack_release;
    rise && pos == 4'h8 && sda |-> ##8 !dev_sda_oe [*8];
  endproperty
  a_nack_release: assert property (p_nack_release)
    else $error("device drove after a refused byte");
  property p_stop_quiet; stop |=> !dev_sda_oe [*8]; endproperty
  a_stop_quiet: assert property (p_stop_quiet)
    else $error("device drove after a stop");
  property p_host_frame;
    $changed(host_sda_oe) && scl && scl_d |-> pos == 4'h1;
  endproperty
  a_host_frame: assert property (p_host_frame)
    else $error("host moved sda under scl high mid byte");
  property p_scl_high;
    $fell(scl) && !(first && pos == 4'h0) |-> hi_len inside {[HI-1:HI+1]};
  endproperty
  a_scl_high: assert property (p_scl_high)
    else $error("scl high time off");
endmodule : two_wire_properties
`default_nettype wire

// ==== testbench/serial_eeprom_read_and_id_lock_tb.sv ====
// Bench: AHB-Lite orders to the host, which talks to the EEPROM.
// Assumes the package, interface and both design ends come first.
`timescale 1ns/1ns
`default_nettype none
module serial_eeprom_read_and_id_lock_tb
  import eeprom_pkg::*;
;
  localparam int unsigned WC = 400;
  localparam logic [2:0]  CS = 3'h5;
  localparam logic [3:0]  AR = ARRAY_TYPE_ID;
  localparam logic [3:0]  ID = ID_TYPE_ID;
  logic        clk, rst_n, hsel, hwrite, hreadyout, id_locked, wbusy;
  logic [31:0] haddr, hwdata, hrdata, rd;
  logic [1:0]  htrans;
  logic [2:0]  hsize;
  int          err_total, n_compared, cyc;
  two_wire_if  tw ();
  eeprom_host #(.QUARTER_CYCLES(4)) i_eeprom_host (.clk, .rst_n, .hsel,
    .haddr, .htrans, .hwrite, .hsize, .hwdata, .hready(hreadyout),
    .hreadyout, .hrdata, .hresp(), .bus(tw));
  eeprom_device #(.WRITE_CYCLES(WC)) i_eeprom_device (.clk, .rst_n,
    .bus(tw), .chip_select_pins(CS), .write_protect(1'b0), .id_locked,
    .write_busy(wbusy));
  two_wire_properties #(.QUARTER_CYCLES(4)) i_two_wire_properties (.clk,
    .rst_n, .host_sda_oe(tw.host_sda_oe), .dev_sda_oe(tw.dev_sda_oe),
    .scl(tw.scl), .sda(tw.sda));
  // ------------------------------------------------------------
  // Clock, hang guard and bus tasks
  // ------------------------------------------------------------
  // A stuck handshake ends the run through the same report.
  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 40000) begin
      err_total++;
      print_verdict();
    end
  end
  task print_verdict();
    $display("compared %0d mismatches %0d", n_compared, err_total);
    if (err_total == 0 && n_compared > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask : print_verdict
  task chk(input logic [31:0] s, input logic [31:0] e, input string n);
    n_compared++;
    if (s !== e) begin
      err_total++;
      $display("[FAIL] %s expected %h seen %h", n, e, s);
    end
  endtask : chk
  // One single word; read data is taken at the closing data edge.
  task ahb(input logic w, input logic [7:0] a, input logic [31:0] d);
    htrans <= HTRANS_NONSEQ;
    haddr  <= {24'h0, a};
    hwrite <= w;
    @(posedge clk);
    while (hreadyout !== 1'b1) @(posedge clk);
    htrans <= 2'h0;
    hwdata <= d;
    @(posedge clk);
    while (hreadyout !== 1'b1) @(posedge clk);
    rd = hrdata;
  endtask : ahb
  // Orders one bus step, then polls until the host is idle again.
  task go(input logic [2:0] op, input logic k = 1'b0);
    ahb(1'b1, CMD_OFFSET, {28'h0, k, op});
    do ahb(1'b0, STATUS_OFFSET, 32'h0);
    while (rd[STATUS_BUSY_BIT] !== 1'b0);
  endtask : go
  task wb(input logic [7:0] b, input logic k);
    ahb(1'b1, TXDATA_OFFSET, {24'h0, b});
    go(OP_WRITE);
    chk(32'(rd[STATUS_ACKED_BIT]), 32'(k), "ack");
  endtask : wb
  task rb(input logic k, input logic [7:0] e);
    go(OP_READ, k);
    ahb(1'b0, RXDATA_OFFSET, 32'h0);
    chk(rd, {24'h0, e}, "rx");
  endtask : rb
  // Word address by a dummy write; r adds the restart for a read.
  task sa(input logic [3:0] t, input logic [15:0] a, input logic r);
    go(OP_START);
    wb({t, CS, 1'b0}, 1'b1);
    wb(a[15:8], 1'b1);
    wb(a[7:0], 1'b1);
    if (r) begin
      go(OP_START);
      wb({t, CS, 1'b1}, 1'b1);
    end
  endtask : sa
  // After a write the bus is probed once inside the write time.
  task stp(input logic w);
    go(OP_STOP);
    chk(32'(wbusy), 32'(w), "busy");
    if (w) begin
      go(OP_START);
      wb({AR, CS, 1'b0}, 1'b0);
      go(OP_STOP);
      repeat (WC + 20) @(posedge clk);
    end
  endtask : stp
  // ------------------------------------------------------------
  // Sequence
  // ------------------------------------------------------------
  initial begin
    hsel   <= 1'b1;
    hwrite <= 1'b0;
    htrans <= 2'h0;
    haddr  <= 32'h0000_0000;
    hwdata <= 32'h0000_0000;
    hsize  <= 3'h2;
    rst_n  <= 1'b0;
    repeat (8) @(posedge clk);
    rst_n <= 1'b1;
    @(posedge clk);
    ahb(1'b0, 8'h40, 32'h0);
    chk(rd, 32'h0, "unmapped");
    sa(AR, 16'h0000, 1'b0);
    wb(8'h44, 1'b1);
    wb(8'h55, 1'b1);
    stp(1'b1);
    sa(AR, 16'hfffe, 1'b0);
    wb(8'h11, 1'b1);
    wb(8'h22, 1'b1);
    stp(1'b1);
    sa(AR, 16'hfffe, 1'b1);
    rb(1'b1, 8'h11);
    rb(1'b1, 8'h22);
    rb(1'b0, 8'h44);
    stp(1'b0);
    go(OP_START);
    wb({AR, CS, 1'b1}, 1'b1);
    rb(1'b0, 8'h55);
    stp(1'b0);
    go(OP_START);
    wb({AR, 3'h2, 1'b1}, 1'b0);
    stp(1'b0);
    sa(ID, 16'h0005, 1'b0);
    wb(8'h66, 1'b1);
    stp(1'b1);
    sa(ID, 16'h03c5, 1'b1);
    rb(1'b0, 8'h66);
    stp(1'b0);
    sa(ID, 16'h0400, 1'b0);
    wb(8'hfd, 1'b1);
    stp(1'b1);
    chk(32'(id_locked), 32'h0, "lock");
    sa(ID, 16'hfcff, 1'b0);
    wb(8'h02, 1'b1);
    stp(1'b1);
    chk(32'(id_locked), 32'h1, "lock");
    sa(ID, 16'h0005, 1'b0);
    wb(8'h77, 1'b0);
    stp(1'b0);
    rst_n <= 1'b0;
    repeat (8) @(posedge clk);
    rst_n <= 1'b1;
    @(posedge clk);
    chk(32'(id_locked), 32'h1, "lock");
    sa(ID, 16'h0005, 1'b1);
    rb(1'b0, 8'h66);
    stp(1'b0);
    print_verdict();
  end
endmodule : serial_eeprom_read_and_id_lock_tb
`default_nettype wire
